// File: spc_port_pins.sv
// Purpose: Drives and senses the six shared port pins and their alternate functions.
// Assumes: Configuration inputs come from CPU registers on the same clock.
// Notes: Pins are split into output, output enable (low drives) and sensed input.
`timescale 1ns/1ns
`include "spc_port_cfg.svh"

// Summary of operation
// - Output pins follow the port data bits, or their timer signal in timer function.
// - Pull-up, open drain, function chosen per pin.
// - Port B pin one only sinks, never drives high.
// - Port B pins two, three have pull-downs.
// - Stop mode freezes pin direction and output.
// - Interrupt pins trigger on rising, falling, both.
// - Key pins interrupt and wake stop; edge selectable.
// - Analog selection forces the pull-up off outside stop mode.
// - Event inputs feed both timers' count sources.
// - External reset pin only when option or register enables.
// - Nonvolatile bits assign oscillator, reset pins.
module spc_port_pins
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic [5:0] pin_in,
   output logic [5:0] pin_out,
   output logic [5:0] pin_oe_n,
   output logic [5:0] pull_up_en,
   output logic [1:0] pull_down_en,
   input wire logic [5:0] port_data,
   input wire logic [5:0] port_dir_out,
   input wire logic [5:0] pull_up_sel,
   input wire logic [5:0] open_drain_sel,
   input wire logic [1:0] pull_down_sel,
   input wire spc_pkg::spc_func_type [5:0] pin_func,
   input wire logic ext_irq_in0_alt_sel,
   input wire spc_pkg::spc_edge_type irq0_edge,
   input wire spc_pkg::spc_edge_type irq1_edge,
   input wire spc_pkg::spc_edge_type key_edge,
   input wire logic stop_mode,
   input wire logic nv_osc_sel,
   input wire logic nv_ext_reset_en,
   input wire logic ext_reset_reg_en,
   input wire logic timer_logic_out_a,
   input wire logic timer_logic_out_b,
   input wire logic wide_pulse_out,
   input wire logic narrow_pulse_out,
   output logic [5:0] pin_level,
   output logic ext_irq_in0,
   output logic ext_irq_in1,
   output logic key_wake_input,
   output logic stop_wake,
   output logic event_count_in0,
   output logic event_count_in1,
   output logic ext_reset_n,
   output logic osc_in_pin,
   output logic osc_mode
);

   // ========================================================================
   // Pin sampling through the synchroniser module.
   // ========================================================================
   spc_sense_if #(.N(`SPC_NPINS)) sense ();  // Raw and clean pin levels.

   assign sense.raw = pin_in;

   spc_pin_sense #(.N(`SPC_NPINS)) u_sense
   (
      .clock (clock),
      .nrst (nrst),
      .sense (sense)
   );

   // True when the edge mode accepts the marked edge.
   function automatic logic edge_hit(input spc_pkg::spc_edge_type mode, input logic r,
                                     input logic f);
      edge_hit = ((mode == spc_pkg::EDGE_RISE || mode == spc_pkg::EDGE_BOTH) && r) ||
                 ((mode == spc_pkg::EDGE_FALL || mode == spc_pkg::EDGE_BOTH) && f);
   endfunction : edge_hit

   // ========================================================================
   // Startup option capture and pin control state.
   // ========================================================================
   logic cfg_taken_r;        // Options have been captured since reset.
   logic cfg_taken_nxt;
   logic nv_osc_r;           // Oscillator owns port B pins two and three.
   logic nv_osc_nxt;
   logic nv_rst_r;           // Code option gives port B pin one to reset.
   logic nv_rst_nxt;
   logic [5:0] out_r;        // Registered pin output levels.
   logic [5:0] out_nxt;
   logic [5:0] oe_n_r;       // Registered output enables, low drives.
   logic [5:0] oe_n_nxt;
   logic [5:0] pu_r;         // Registered pull-up enables.
   logic [5:0] pu_nxt;
   logic [1:0] pd_r;         // Registered pull-down enables.
   logic [1:0] pd_nxt;
   logic [5:0] lvl_r;        // Port read value.
   logic [5:0] lvl_nxt;
   logic irq0_r;             // First interrupt pulse.
   logic irq0_nxt;
   logic irq1_r;             // Second interrupt pulse.
   logic irq1_nxt;
   logic key_r;              // Key interrupt pulse.
   logic key_nxt;
   logic wake_r;             // Stop release pulse.
   logic wake_nxt;
   logic ec0_r;              // First event count level.
   logic ec0_nxt;
   logic ec1_r;              // Second event count level.
   logic ec1_nxt;
   logic rst_n_r;            // External reset level.
   logic rst_n_nxt;
   logic osc_r;              // Oscillator input level.
   logic osc_nxt;
   logic rst_active;         // Reset function currently owns its pin.
   logic [5:0] tmr_src;      // Timer output wired to each pin; port A pin one gets zero.
   logic [5:0] od_force;     // Pins that can only sink.

   assign rst_active = nv_rst_r | ext_reset_reg_en;
   assign tmr_src = {timer_logic_out_b, narrow_pulse_out, wide_pulse_out, wide_pulse_out,
                     1'b0, timer_logic_out_a};
   assign od_force = 6'h08;  // Port B pin one has no high-side driver.

   // Next values for every pin. The loop keeps each pin's decision
   // independent, so any mix of functions can be set at once.
   always_comb
   begin
      logic drive_en;
      logic drive_val;
      logic od;
      logic locked;
      logic analog;
      logic key_any;
      int src0;
      drive_en = 1'b0;
      drive_val = 1'b0;
      od = 1'b0;
      locked = 1'b0;
      analog = 1'b0;
      key_any = 1'b0;
      src0 = ext_irq_in0_alt_sel ? `SPC_PIN_A2 : `SPC_PIN_A0;
      // The options are caught once, in the first cycle after reset release.
      cfg_taken_nxt = 1'b1;
      nv_osc_nxt = cfg_taken_r ? nv_osc_r : nv_osc_sel;
      nv_rst_nxt = cfg_taken_r ? nv_rst_r : nv_ext_reset_en;
      out_nxt = out_r;
      oe_n_nxt = oe_n_r;
      pu_nxt = pu_r;
      pd_nxt = pd_r;
      lvl_nxt = '0;
      for (int i = 0; i < `SPC_NPINS; i++)
      begin
         locked = (nv_osc_r && (i == `SPC_PIN_B2 || i == `SPC_PIN_B3)) ||
                  (rst_active && i == `SPC_PIN_B1);
         analog = (pin_func[i] == spc_pkg::FUNC_ANALOG);
         // Timer function drives its own signal; otherwise port data.
         drive_val = (pin_func[i] == spc_pkg::FUNC_TIMER) ? tmr_src[i] : port_data[i];
         drive_en = !locked && !analog &&
                    ((pin_func[i] == spc_pkg::FUNC_TIMER) || port_dir_out[i]);
         od = open_drain_sel[i] | od_force[i];
         // A frozen pin keeps what it had on entry to stop mode.
         if (!stop_mode)
         begin
            out_nxt[i] = od ? 1'b0 : drive_val;
            oe_n_nxt[i] = !(drive_en && (!od || !drive_val));
            pu_nxt[i] = pull_up_sel[i] && !analog && !locked;
         end
         // Analog and oscillator pins read as zero rather than a floating level.
         lvl_nxt[i] = (analog || locked) ? 1'b0 : sense.lvl[i];
         if (pin_func[i] == spc_pkg::FUNC_KEY && !locked &&
             edge_hit(key_edge, sense.rise[i], sense.fall[i]))
         begin
            key_any = 1'b1;
         end
      end
      if (!stop_mode)
      begin
         pd_nxt[0] = pull_down_sel[0] && !nv_osc_r;
         pd_nxt[1] = pull_down_sel[1] && !nv_osc_r;
      end
      irq0_nxt = (pin_func[src0] == spc_pkg::FUNC_IRQ) &&
                 edge_hit(irq0_edge, sense.rise[src0], sense.fall[src0]);
      irq1_nxt = (pin_func[`SPC_PIN_A1] == spc_pkg::FUNC_IRQ) &&
                 edge_hit(irq1_edge, sense.rise[`SPC_PIN_A1],
                          sense.fall[`SPC_PIN_A1]);
      key_nxt = key_any;
      wake_nxt = key_any && stop_mode;
      // Event levels go out once and are fanned to both timers by the user.
      ec0_nxt = sense.lvl[src0];
      ec1_nxt = sense.lvl[`SPC_PIN_A1];
      rst_n_nxt = rst_active ? sense.lvl[`SPC_PIN_B1] : 1'b1;
      osc_nxt = nv_osc_r ? sense.lvl[`SPC_PIN_B3] : 1'b0;
   end

   // Registers only. Reset releases every pin as an undriven input.
   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         cfg_taken_r <= 1'b0;
         nv_osc_r <= 1'b0;
         nv_rst_r <= 1'b0;
         out_r <= `SPC_OUT_RST;
         oe_n_r <= `SPC_OE_N_RST;
         pu_r <= `SPC_PULL_RST;
         pd_r <= `SPC_PD_RST;
         lvl_r <= '0;
         irq0_r <= 1'b0;
         irq1_r <= 1'b0;
         key_r <= 1'b0;
         wake_r <= 1'b0;
         ec0_r <= 1'b0;
         ec1_r <= 1'b0;
         rst_n_r <= 1'b1;
         osc_r <= 1'b0;
      end
      else
      begin
         cfg_taken_r <= cfg_taken_nxt;
         nv_osc_r <= nv_osc_nxt;
         nv_rst_r <= nv_rst_nxt;
         out_r <= out_nxt;
         oe_n_r <= oe_n_nxt;
         pu_r <= pu_nxt;
         pd_r <= pd_nxt;
         lvl_r <= lvl_nxt;
         irq0_r <= irq0_nxt;
         irq1_r <= irq1_nxt;
         key_r <= key_nxt;
         wake_r <= wake_nxt;
         ec0_r <= ec0_nxt;
         ec1_r <= ec1_nxt;
         rst_n_r <= rst_n_nxt;
         osc_r <= osc_nxt;
      end
   end

   // ========================================================================
   // Outputs, all straight from flops.
   // ========================================================================
   assign pin_out = out_r;
   assign pin_oe_n = oe_n_r;
   assign pull_up_en = pu_r;
   assign pull_down_en = pd_r;
   assign pin_level = lvl_r;
   assign ext_irq_in0 = irq0_r;
   assign ext_irq_in1 = irq1_r;
   assign key_wake_input = key_r;
   assign stop_wake = wake_r;
   assign event_count_in0 = ec0_r;
   assign event_count_in1 = ec1_r;
   assign ext_reset_n = rst_n_r;
   assign osc_in_pin = osc_r;
   assign osc_mode = nv_osc_r;

   // ========================================================================
   // Checks.
   // ========================================================================
   data_drive_a: assert property (@(posedge clock) disable iff (!nrst)
      (pin_func[1] == spc_pkg::FUNC_PORT && port_dir_out[1] && !open_drain_sel[1] &&
       !stop_mode) |=> (!pin_oe_n[1] && pin_out[1] == $past(port_data[1])))
      else $error("Output pin does not follow its data bit.");
   od_never_high_a: assert property (@(posedge clock) disable iff (!nrst)
      !pin_oe_n[3] |-> !pin_out[3])
      else $error("Sink-only pin driven high.");
   pd_from_sel_a: assert property (@(posedge clock) disable iff (!nrst)
      $rose(pull_down_en[0]) |-> $past(pull_down_sel[0]))
      else $error("Pull-down enabled without selection.");
   stop_hold_a: assert property (@(posedge clock) disable iff (!nrst)
      (stop_mode && $past(stop_mode)) |-> ($stable(pin_out) && $stable(pin_oe_n)))
      else $error("Pin state changed during stop mode.");
   irq_edge_on_a: assert property (@(posedge clock) disable iff (!nrst)
      ext_irq_in0 |-> $past(irq0_edge) != spc_pkg::EDGE_OFF)
      else $error("Interrupt raised with edge detection off.");
   wake_key_a: assert property (@(posedge clock) disable iff (!nrst)
      stop_wake |-> key_wake_input)
      else $error("Stop release without key interrupt.");
   analog_pu_off_a: assert property (@(posedge clock) disable iff (!nrst)
      (pin_func[0] == spc_pkg::FUNC_ANALOG && !stop_mode) |=> !pull_up_en[0])
      else $error("Pull-up left on for analog pin.");
   reset_gate_a: assert property (@(posedge clock) disable iff (!nrst)
      !rst_active |=> ext_reset_n)
      else $error("External reset seen while disabled.");
   option_hold_a: assert property (@(posedge clock) disable iff (!nrst)
      cfg_taken_r |=> (cfg_taken_r && $stable(nv_osc_r) && $stable(nv_rst_r)))
      else $error("Startup option changed after capture.");
   reset_idle_a: assert property (@(posedge clock)
      !nrst |=> (pin_oe_n == `SPC_OE_N_RST && pull_up_en == `SPC_PULL_RST &&
                 pull_down_en == `SPC_PD_RST))
      else $error("Pins not released by reset.");

endmodule : spc_port_pins

// File: spc_port_cfg.svh
// Purpose: Constants for the shared port pin control block.
// Assumes: Pin vector order is port_a_pin0..2 then port_b_pin1..3.
// Notes: Definitions only.
`ifndef SPC_PORT_CFG_SVH
`define SPC_PORT_CFG_SVH

// ==========================================================================
// Pin indices within the six-bit pin vectors.
// ==========================================================================
`define SPC_NPINS 6
`define SPC_PIN_A0 0
`define SPC_PIN_A1 1
`define SPC_PIN_A2 2
`define SPC_PIN_B1 3
`define SPC_PIN_B2 4
`define SPC_PIN_B3 5

// ==========================================================================
// Reset values of the registered pin controls.
// ==========================================================================
`define SPC_OE_N_RST 6'h3f
`define SPC_OUT_RST 6'h00
`define SPC_PULL_RST 6'h00
`define SPC_PD_RST 2'h0

`endif

// File: spc_pkg.sv
// Purpose: Types shared by the shared port pin control modules.
// Assumes: Nothing beyond the configuration header.
// Notes: Encodings are fixed so that software sees stable codes.
package spc_pkg;

   // ========================================================================
   // Per-pin function selection.
   // ========================================================================
   typedef enum logic [2:0]
   {
      FUNC_PORT = 3'h0,
      FUNC_KEY = 3'h1,
      FUNC_ANALOG = 3'h2,
      FUNC_IRQ = 3'h3,
      FUNC_TIMER = 3'h4
   } spc_func_type;

   // ========================================================================
   // Edge selection for interrupt and key inputs.
   // ========================================================================
   typedef enum logic [1:0]
   {
      EDGE_OFF = 2'h0,
      EDGE_RISE = 2'h1,
      EDGE_FALL = 2'h2,
      EDGE_BOTH = 2'h3
   } spc_edge_type;

endpackage : spc_pkg

// File: spc_sense_if.sv
// Purpose: Carries raw pin levels to the sampler and clean levels back.
// Assumes: One clock domain.
// Notes: Edge pulses last one clock.
`timescale 1ns/1ns
interface spc_sense_if #(parameter int N = 6);
   logic [N-1:0] raw;   // Raw pin levels from outside.
   logic [N-1:0] lvl;   // Synchronised levels.
   logic [N-1:0] rise;  // One-cycle rising edge marks.
   logic [N-1:0] fall;  // One-cycle falling edge marks.
   modport det (input raw, output lvl, output rise, output fall);
   modport usr (output raw, input lvl, input rise, input fall);
endinterface : spc_sense_if

// File: spc_pin_sense.sv
// Purpose: Synchronises pin inputs and marks their edges.
// Assumes: Pins change asynchronously to clock.
// Notes: Three flops per pin; the first is read only by the second.
`timescale 1ns/1ns
module spc_pin_sense #(parameter int N = 6)
(
   input wire logic clock,
   input wire logic nrst,
   spc_sense_if.det sense
);

   // ========================================================================
   // Synchroniser chain state.
   // ========================================================================
   logic [N-1:0] s1_r;   // First stage, metastability catcher.
   logic [N-1:0] s2_r;   // Second stage, the clean level.
   logic [N-1:0] s3_r;   // Previous clean level for edge marking.
   logic [N-1:0] s1_nxt;
   logic [N-1:0] s2_nxt;
   logic [N-1:0] s3_nxt;

   // Next values simply shift along the chain.
   always_comb
   begin
      s1_nxt = sense.raw;
      s2_nxt = s1_r;
      s3_nxt = s2_r;
   end

   // Register the chain. It keeps sampling through reset on purpose: clearing it
   // would make a pin that idles high show a false rising edge after release.
   always_ff @(posedge clock)
   begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
   end

   // ========================================================================
   // Per-pin edge marks, built only from the second and third stages.
   // ========================================================================
   genvar g;
   generate
      for (g = 0; g < N; g++)
      begin : g_edge
         assign sense.lvl[g] = s2_r[g];
         assign sense.rise[g] = s2_r[g] & ~s3_r[g];
         assign sense.fall[g] = ~s2_r[g] & s3_r[g];
      end
   endgenerate

   // A pin can never show both edges in one cycle.
   edge_exclusive_a: assert property (@(posedge clock) disable iff (!nrst)
      !(|(sense.rise & sense.fall)))
      else $error("Rise and fall marked together on one pin.");

endmodule : spc_pin_sense

// File: spc_pin_world.sv
// Purpose: Models the outside world that sits on the six shared port pins.
// Assumes: The bench chooses which pins an outside source holds, and at what level.
// Notes: A pin that nobody holds flips every cycle, so a stale value never passes.
`timescale 1ns/1ns
module spc_pin_world
(
   input wire logic clock,
   input wire logic [5:0] pin_out,
   input wire logic [5:0] pin_oe_n,
   input wire logic [5:0] pull_up_en,
   input wire logic [1:0] pull_down_en,
   input wire logic [5:0] src_en,
   input wire logic [5:0] src_val,
   output logic [5:0] pin_wire
);
   // ======================================================================
   // Undriven pin pattern
   // ======================================================================
   logic [5:0] float_r = 6'h15; // Stand-in level for a pin left floating.
   logic [5:0] pd_all; // Pull-downs placed at their pin positions.

   assign pd_all = {pull_down_en, 4'h0};

   // The pattern changes every cycle because a real floating pin has no value.
   always @(posedge clock)
   begin
      float_r <= ~float_r;
   end

   // ======================================================================
   // Wire resolution
   // ======================================================================
   // The device drive wins, then an outside source, then pulls, then nothing.
   // Contention is not modelled: the bench releases its source where the device drives.
   always_comb
   begin
      for (int i = 0; i < 6; i++)
      begin
         pin_wire[i] = !pin_oe_n[i] ? pin_out[i] : src_en[i] ? src_val[i] :
            pull_up_en[i] ? 1'b1 : pd_all[i] ? 1'b0 : float_r[i];
      end
   end
endmodule : spc_pin_world

// File: shared_port_pin_control_test.sv
// Purpose: Self-checking bench for the shared port pin control block.
// Assumes: Inputs change on the falling clock edge; outputs are read there too.
// Notes: Edge pulses are counted over a window, so exact latency is not assumed.
`timescale 1ns/1ns
module shared_port_pin_control_test;
   // ======================================================================
   // Stimulus and observed signals
   // ======================================================================
   logic clock = 1'b0; // 250 MHz system clock.
   logic nrst = 1'b0; // Synchronous reset, active low.
   logic [5:0] pin_in, pin_out, pin_oe_n, pull_up_en, pin_level;
   logic [5:0] port_data = 6'h00, port_dir_out = 6'h00, pull_up_sel = 6'h00;
   logic [5:0] open_drain_sel = 6'h00, src_en = 6'h3f, src_val = 6'h00;
   logic [1:0] pull_down_sel = 2'h0, pull_down_en;
   spc_pkg::spc_func_type [5:0] pin_func;
   spc_pkg::spc_edge_type irq0_edge = spc_pkg::EDGE_OFF, irq1_edge = spc_pkg::EDGE_OFF;
   spc_pkg::spc_edge_type key_edge = spc_pkg::EDGE_OFF;
   logic ext_irq_in0_alt_sel = 1'b0, stop_mode = 1'b0, nv_osc_sel = 1'b0;
   logic nv_ext_reset_en = 1'b0, ext_reset_reg_en = 1'b0, tmr_a = 1'b0;
   logic ext_irq_in0, ext_irq_in1, key_wake_input, stop_wake;
   logic event_count_in0, event_count_in1, ext_reset_n, osc_in_pin, osc_mode;
   int error_cnt = 0, num_checks = 0; // Mismatches and comparisons.
   int n_irq0 = 0, n_irq1 = 0, n_key = 0, n_wake = 0; // Pulse tallies.

   initial
   begin
      forever #2 clock = ~clock;
   end

   // ======================================================================
   // Design and outside world
   // ======================================================================
   // All four timer sources share one bench signal; timer pins are told from port data.
   spc_port_pins dut (.clock(clock), .nrst(nrst), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n), .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
      .port_data(port_data), .port_dir_out(port_dir_out), .pull_up_sel(pull_up_sel),
      .open_drain_sel(open_drain_sel), .pull_down_sel(pull_down_sel),
      .pin_func(pin_func), .ext_irq_in0_alt_sel(ext_irq_in0_alt_sel), .irq0_edge(irq0_edge),
      .irq1_edge(irq1_edge), .key_edge(key_edge), .stop_mode(stop_mode),
      .nv_osc_sel(nv_osc_sel), .nv_ext_reset_en(nv_ext_reset_en),
      .ext_reset_reg_en(ext_reset_reg_en), .timer_logic_out_a(tmr_a),
      .timer_logic_out_b(tmr_a), .wide_pulse_out(tmr_a), .narrow_pulse_out(tmr_a),
      .pin_level(pin_level), .ext_irq_in0(ext_irq_in0), .ext_irq_in1(ext_irq_in1),
      .key_wake_input(key_wake_input), .stop_wake(stop_wake),
      .event_count_in0(event_count_in0), .event_count_in1(event_count_in1),
      .ext_reset_n(ext_reset_n), .osc_in_pin(osc_in_pin), .osc_mode(osc_mode));

   spc_pin_world world (.clock(clock), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .src_en(src_en),
      .src_val(src_val), .pin_wire(pin_in));

   // Pulses last one cycle, so each rising edge tallies what it sees high.
   always @(posedge clock)
   begin
      n_irq0 <= n_irq0 + int'(ext_irq_in0 === 1'b1);
      n_irq1 <= n_irq1 + int'(ext_irq_in1 === 1'b1);
      n_key <= n_key + int'(key_wake_input === 1'b1);
      n_wake <= n_wake + int'(stop_wake === 1'b1);
   end

   // ======================================================================
   // Shared tasks
   // ======================================================================
   task automatic step(input int n);
      repeat (n) @(negedge clock);
   endtask : step

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic print_verdict();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : print_verdict

   // Reset is held three cycles so the pin synchronisers fill with real levels.
   task automatic do_reset();
      nrst = 1'b0;
      step(3);
      nrst = 1'b1;
      step(2);
   endtask : do_reset

   function automatic int cnt(input int which);
      return which == 0 ? n_irq0 : which == 1 ? n_irq1 : n_key;
   endfunction : cnt

   // ======================================================================
   // Scenarios
   // ======================================================================
   task automatic test_outputs();
      src_en = 6'h00;
      port_dir_out = 6'h3f;
      port_data = 6'h3f;
      step(2);
      check(pin_oe_n, 6'h08);
      check(pin_out & 6'h37, 6'h37);
      port_data = 6'h01;
      open_drain_sel = 6'h01;
      step(2);
      check(pin_oe_n, 6'h01);
      check(pin_out & 6'h3e, 6'h00);
      open_drain_sel = 6'h00;
      pin_func[0] = spc_pkg::FUNC_TIMER;
      pin_func[2] = spc_pkg::FUNC_TIMER;
      pin_func[4] = spc_pkg::FUNC_TIMER;
      pin_func[5] = spc_pkg::FUNC_TIMER;
      tmr_a = 1'b1;
      step(2);
      check(pin_out, 6'h35);
      tmr_a = 1'b0;
      step(2);
      check(pin_out, 6'h00);
      pin_func = {6{spc_pkg::FUNC_PORT}};
      port_dir_out = 6'h00;
      src_en = 6'h3f;
   endtask : test_outputs

   task automatic test_pulls();
      src_en = 6'h00;
      pull_up_sel = 6'h3f;
      step(6);
      check(pull_up_en, 6'h3f);
      check(pin_level, 6'h3f);
      pull_up_sel = 6'h00;
      pull_down_sel = 2'h3;
      step(6);
      check(pull_down_en, 2'h3);
      check(pin_level & 6'h30, 6'h00);
      pull_down_sel = 2'h2;
      pull_up_sel = 6'h3f;
      pin_func[0] = spc_pkg::FUNC_ANALOG;
      pin_func[5] = spc_pkg::FUNC_ANALOG;
      step(2);
      check(pull_down_en, 2'h2);
      check(pull_up_en, 6'h1e);
      pin_func[0] = spc_pkg::FUNC_PORT;
      pin_func[5] = spc_pkg::FUNC_PORT;
      {pull_up_sel, pull_down_sel, src_en} = {6'h00, 2'h0, 6'h3f};
   endtask : test_pulls

   // Changes made on the very edge that enters stop must not reach the pins.
   task automatic test_stop_hold();
      src_en = 6'h38;
      port_dir_out = 6'h07;
      port_data = 6'h05;
      step(2);
      stop_mode = 1'b1;
      port_data = 6'h02;
      port_dir_out = 6'h00;
      step(3);
      check(pin_oe_n, 6'h38);
      check(pin_out & 6'h07, 6'h05);
      stop_mode = 1'b0;
      step(2);
      check(pin_oe_n, 6'h3f);
      src_en = 6'h3f;
   endtask : test_stop_hold

   // Every edge code on one pin; the rising count is checked before the fall.
   task automatic edge_case(input int idx, input int which, input logic alt,
      input logic on);
      int base;
      for (int e = 0; e < 4; e++)
      begin
         ext_irq_in0_alt_sel = alt;
         irq0_edge = spc_pkg::spc_edge_type'(e[1:0]);
         irq1_edge = spc_pkg::spc_edge_type'(e[1:0]);
         key_edge = spc_pkg::spc_edge_type'(e[1:0]);
         pin_func[idx] = which == 2 ? spc_pkg::FUNC_KEY : spc_pkg::FUNC_IRQ;
         step(6);
         base = cnt(which);
         src_val[idx] = 1'b1;
         step(8);
         check(8'(cnt(which) - base), on ? 8'(e & 1) : 8'h00);
         src_val[idx] = 1'b0;
         step(8);
         check(8'(cnt(which) - base), on ? 8'((e & 1) + (e >> 1)) : 8'h00);
      end
      pin_func[idx] = spc_pkg::FUNC_PORT;
   endtask : edge_case

   task automatic test_wake();
      int base;
      pin_func[4] = spc_pkg::FUNC_KEY;
      key_edge = spc_pkg::EDGE_RISE;
      step(6);
      base = n_wake;
      src_val[4] = 1'b1;
      step(8);
      check(8'(n_wake - base), 8'h00);
      stop_mode = 1'b1;
      src_val[4] = 1'b0;
      step(6);
      src_val[4] = 1'b1;
      step(8);
      check(8'(n_wake - base), 8'h01);
      stop_mode = 1'b0;
      src_val[4] = 1'b0;
      pin_func[4] = spc_pkg::FUNC_PORT;
   endtask : test_wake

   task automatic test_events();
      pin_func[2:0] = {3{spc_pkg::FUNC_IRQ}};
      ext_irq_in0_alt_sel = 1'b0;
      src_val[1:0] = 2'h3;
      step(6);
      check(event_count_in0, 1'b1);
      check(event_count_in1, 1'b1);
      ext_irq_in0_alt_sel = 1'b1;
      step(6);
      check(event_count_in0, 1'b0);
      src_val[1:0] = 2'h0;
      pin_func[2:0] = {3{spc_pkg::FUNC_PORT}};
      ext_irq_in0_alt_sel = 1'b0;
   endtask : test_events

   // The reset register enable also locks the pin against port output.
   task automatic test_ext_reset();
      src_val[3] = 1'b0;
      step(6);
      check(ext_reset_n, 1'b1);
      ext_reset_reg_en = 1'b1;
      port_dir_out[3] = 1'b1;
      step(6);
      check(ext_reset_n, 1'b0);
      check(pin_oe_n[3], 1'b1);
      src_val[3] = 1'b1;
      step(6);
      check(ext_reset_n, 1'b1);
      {ext_reset_reg_en, port_dir_out} = {1'b0, 6'h00};
   endtask : test_ext_reset

   // Both options come from nonvolatile bits, so they need a fresh reset.
   task automatic test_options();
      {nv_osc_sel, nv_ext_reset_en} = 2'h3;
      do_reset();
      check(osc_mode, 1'b1);
      {pull_down_sel, port_dir_out, src_val} = {2'h3, 6'h3f, 6'h20};
      src_en = 6'h38;
      step(6);
      check(pull_down_en, 2'h0);
      check(pin_oe_n & 6'h38, 6'h38);
      check(osc_in_pin, 1'b1);
      check(ext_reset_n, 1'b0);
      src_val[5] = 1'b0;
      step(6);
      check(osc_in_pin, 1'b0);
   endtask : test_options

   // ======================================================================
   // Main sequence and watchdog
   // ======================================================================
   initial
   begin
      pin_func = {6{spc_pkg::FUNC_PORT}};
      do_reset();
      check(pin_oe_n, 6'h3f);
      check({pull_up_en, pull_down_en}, 8'h00);
      check({ext_reset_n, osc_mode, pin_out}, 8'h80);
      test_outputs();
      test_pulls();
      test_stop_hold();
      edge_case(0, 0, 1'b0, 1'b1);
      edge_case(2, 0, 1'b1, 1'b1);
      edge_case(0, 0, 1'b1, 1'b0);
      edge_case(1, 1, 1'b0, 1'b1);
      edge_case(4, 2, 1'b0, 1'b1);
      test_wake();
      test_events();
      test_ext_reset();
      test_options();
      print_verdict();
   end

   // The tests take under two thousand cycles; ten times that means a hang.
   initial
   begin
      repeat (20000) @(posedge clock);
      error_cnt++;
      print_verdict();
   end
endmodule : shared_port_pin_control_test
